/* logic/prio_pkg.sv */
// Purpose: Shared constants for the interrupt priority field block.
// Assumes: AXI4-Lite register access, 32-bit data, 16-bit registers in low half.
// Notes: Offsets are byte addresses chosen for this block.
// Notes on behaviour
// - Field value 111 is level seven, highest
// - Field value 000 disables the source entirely
// - Values one to seven are numeric levels
// - Unimplemented bits read zero, ignore writes
// - Every field resets to binary 100
// - Register zero: timer1, outcmp1, incap1, extirq0
// - Register one: timer2, outcmp2, incap2 fields
// - Register two: uart1 rx, spi1 event/fault, timer3
// - Register three: flashprog, conv done, uart1 tx
// - Register four: pinchange, comparator, i2c1 master/slave
// - Register five: only extirq1 in bits 2-0
// - Implemented bits read back last written value
// - Zero enable blocks the request always
package prio_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int NUM_REGS = 6;
    localparam int NUM_SRC = 19;
    localparam logic [7:0] PRIO_CTRL_0_OFS = 8'h00;
    localparam logic [7:0] PRIO_CTRL_1_OFS = 8'h04;
    localparam logic [7:0] PRIO_CTRL_2_OFS = 8'h08;
    localparam logic [7:0] PRIO_CTRL_3_OFS = 8'h0C;
    localparam logic [7:0] PRIO_CTRL_4_OFS = 8'h10;
    localparam logic [7:0] PRIO_CTRL_5_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    // Writable bit masks per register
    localparam logic [15:0] MASK_0 = 16'h7777;
    localparam logic [15:0] MASK_1 = 16'h7770;
    localparam logic [15:0] MASK_2 = 16'h7777;
    localparam logic [15:0] MASK_3 = 16'h7077;
    localparam logic [15:0] MASK_4 = 16'h7777;
    localparam logic [15:0] MASK_5 = 16'h0007;
    // Reset value: every field binary 100
    localparam logic [15:0] RESET_ALL = 16'h4444;
    // ------------------------------------------------------------
    // Levels and responses
    // ------------------------------------------------------------
    localparam logic [2:0] LEVEL_OFF = 3'h0;
    localparam logic [2:0] LEVEL_TOP = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_RESP = 1'b1
    } bus_state_t;
endpackage : prio_pkg

/* logic/prio_arbiter.sv */
// Purpose: Picks the highest-level pending, enabled source.
// Assumes: Levels arrive flattened, three bits per source.
// Notes: Purely combinational; lowest index wins ties.
`timescale 1ns/1ps
`default_nettype none
module prio_arbiter #(
    parameter int N = 19
) (
    input wire logic [N-1:0] pend,
    input wire logic [N-1:0] enab,
    input wire logic [3*N-1:0] levels,
    output logic valid,
    output logic [4:0] winner,
    output logic [2:0] win_level
);
    // ------------------------------------------------------------
    // Per-source qualification and chained compare
    // ------------------------------------------------------------
    logic [N-1:0] qual; // Source eligible this cycle
    logic [2:0] best [0:N]; // Running best level along the chain
    logic [4:0] best_idx [0:N]; // Running best source index
    assign best[0] = prio_pkg::LEVEL_OFF;
    assign best_idx[0] = 5'h00;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_src
            // Level zero disables and a clear enable blocks
            assign qual[g] = pend[g] && enab[g] && (levels[3*g +: 3] != prio_pkg::LEVEL_OFF);
            // Strictly greater keeps the earlier index on a tie
            assign best[g+1] = (qual[g] && levels[3*g +: 3] > best[g]) ? levels[3*g +: 3] : best[g];
            assign best_idx[g+1] = (qual[g] && levels[3*g +: 3] > best[g]) ? 5'(g) : best_idx[g];
        end
    endgenerate
    assign valid = |qual;
    assign winner = best_idx[N];
    assign win_level = best[N];
endmodule : prio_arbiter
`default_nettype wire

/* logic/prio_fields.sv */
// Purpose: Priority field registers with AXI4-Lite access and arbitration.
// Assumes: One write and one read under way at most; sources on CORE_CLK.
// Notes: Answers one cycle after the request is complete.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module prio_fields (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic [18:0] SRC_PEND,
    input wire logic [18:0] SRC_ENAB,
    output logic REQ_VALID,
    output logic [4:0] REQ_SRC,
    output logic [2:0] REQ_LEVEL
);
    // ------------------------------------------------------------
    // Storage and masks
    // ------------------------------------------------------------
    // Reserved bits are masked on every store, so a read never needs
    // to know which bits are real; the read path masks once more for
    // safety against a future store path that forgets.
    logic [15:0] prio_reg [0:prio_pkg::NUM_REGS-1]; // Priority registers
    // Implemented bits per register; a constant so the reset branch
    // assigns constants only
    localparam logic [15:0] mask [0:prio_pkg::NUM_REGS-1] = '{
        prio_pkg::MASK_0,
        prio_pkg::MASK_1,
        prio_pkg::MASK_2,
        prio_pkg::MASK_3,
        prio_pkg::MASK_4,
        prio_pkg::MASK_5
    };
    // Named field views, one per source
    logic [2:0] timer1_level; // Timer1
    logic [2:0] outcmp1_level; // Output compare 1
    logic [2:0] incap1_level; // Input capture 1
    logic [2:0] extirq0_level; // External interrupt 0
    logic [2:0] timer2_level; // Timer2
    logic [2:0] outcmp2_level; // Output compare 2
    logic [2:0] incap2_level; // Input capture 2
    logic [2:0] uart1_rx_level; // UART1 receive
    logic [2:0] spi1_event_level; // SPI1 event
    logic [2:0] spi1_fault_level; // SPI1 fault
    logic [2:0] timer3_level; // Timer3
    logic [2:0] flashprog_level; // Flash programming done
    logic [2:0] conv_done_level; // Conversion complete
    logic [2:0] uart1_tx_level; // UART1 transmit
    logic [2:0] pinchange_level; // Pin change
    logic [2:0] comparator_level; // Comparator
    logic [2:0] i2c1_master_level; // I2C1 master event
    logic [2:0] i2c1_slave_level; // I2C1 slave event
    logic [2:0] extirq1_level; // External interrupt 1
    assign timer1_level = prio_reg[0][14:12];
    assign outcmp1_level = prio_reg[0][10:8];
    assign incap1_level = prio_reg[0][6:4];
    assign extirq0_level = prio_reg[0][2:0];
    assign timer2_level = prio_reg[1][14:12];
    assign outcmp2_level = prio_reg[1][10:8];
    assign incap2_level = prio_reg[1][6:4];
    assign uart1_rx_level = prio_reg[2][14:12];
    assign spi1_event_level = prio_reg[2][10:8];
    assign spi1_fault_level = prio_reg[2][6:4];
    assign timer3_level = prio_reg[2][2:0];
    assign flashprog_level = prio_reg[3][14:12];
    assign conv_done_level = prio_reg[3][6:4];
    assign uart1_tx_level = prio_reg[3][2:0];
    assign pinchange_level = prio_reg[4][14:12];
    assign comparator_level = prio_reg[4][10:8];
    assign i2c1_master_level = prio_reg[4][6:4];
    assign i2c1_slave_level = prio_reg[4][2:0];
    assign extirq1_level = prio_reg[5][2:0];
    // Source order 0..18 follows the register order above
    logic [56:0] levels;
    assign levels = {extirq1_level, i2c1_slave_level, i2c1_master_level,
        comparator_level, pinchange_level, uart1_tx_level, conv_done_level,
        flashprog_level, timer3_level, spi1_fault_level, spi1_event_level,
        uart1_rx_level, incap2_level, outcmp2_level, timer2_level,
        extirq0_level, incap1_level, outcmp1_level, timer1_level};

    // ------------------------------------------------------------
    // Write channel: address and data taken in either order
    // ------------------------------------------------------------
    // Each half is parked until its partner arrives; a new write's halves are
    // taken while the last response waits, but it is not performed until then
    logic aw_held; // Write address captured
    logic w_held; // Write data captured
    logic [7:0] aw_addr; // Captured write address
    logic [31:0] w_data; // Captured write data
    logic [3:0] w_strb; // Captured strobes
    logic do_write; // Both halves present, response slot free
    logic [2:0] wr_idx; // Word index of the write
    logic wr_hit; // Write targets a priority register
    assign AWREADY = !aw_held;
    assign WREADY = !w_held;
    assign do_write = aw_held && w_held && !BVALID;
    assign wr_idx = aw_addr[4:2];
    assign wr_hit = (aw_addr[1:0] == 2'h0) && (aw_addr <= prio_pkg::PRIO_CTRL_5_OFS);

    // Address capture
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (AWVALID && AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // Data capture
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (WVALID && WREADY) begin
            w_held <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Register update; byte lanes honoured, unimplemented bits dropped
    // Strobe bits 3:2 are ignored; only the low half holds fields
    genvar r;
    generate
        for (r = 0; r < prio_pkg::NUM_REGS; r++) begin : g_reg
            logic [15:0] lane; // Bits enabled by strobes
            assign lane = {{8{w_strb[1]}}, {8{w_strb[0]}}};
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    prio_reg[r] <= prio_pkg::RESET_ALL & mask[r];
                end else if (do_write && wr_hit && wr_idx == 3'(r)) begin
                    // Masked merge keeps reserved bits at zero
                    prio_reg[r] <= ((w_data[15:0] & lane) | (prio_reg[r] & ~lane)) & mask[r];
                end
            end
        end
    endgenerate

    // Write response
    // Held until taken; the next write waits for the slot to free
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            BVALID <= 1'b0;
            BRESP <= prio_pkg::RESP_OKAY;
        end else if (do_write) begin
            BVALID <= 1'b1;
            // Status word is read-only; a write there is refused
            BRESP <= wr_hit ? prio_pkg::RESP_OKAY : prio_pkg::RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic [4:0] last_src; // Registered arbitration result for status reads
    logic last_valid;
    logic [2:0] last_level;
    assign ARREADY = !RVALID;

    // Read data and response
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= prio_pkg::RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= prio_pkg::RESP_OKAY;
            if (ARADDR[1:0] == 2'h0 && ARADDR <= prio_pkg::PRIO_CTRL_5_OFS) begin
                // Upper half and reserved bits read zero
                RDATA <= {16'h0000, prio_reg[ARADDR[4:2]] & mask[ARADDR[4:2]]};
            end else if (ARADDR == prio_pkg::STATUS_OFS) begin
                RDATA <= {23'h000000, last_valid, last_src, last_level};
            end else begin
                RDATA <= 32'h0000_0000;
                RRESP <= prio_pkg::RESP_SLVERR;
            end
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    logic arb_valid;
    logic [4:0] arb_src;
    logic [2:0] arb_level;
    prio_arbiter #(
        .N(prio_pkg::NUM_SRC)
    ) u_arb (
        .pend(SRC_PEND),
        .enab(SRC_ENAB),
        .levels(levels),
        .valid(arb_valid),
        .winner(arb_src),
        .win_level(arb_level)
    );

    // Registered request toward the CPU
    // One cycle of latency keeps the long compare chain off the outputs
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            last_valid <= 1'b0;
            last_src <= 5'h00;
            last_level <= 3'h0;
        end else begin
            last_valid <= arb_valid;
            last_src <= arb_valid ? arb_src : 5'h00;
            last_level <= arb_valid ? arb_level : 3'h0;
        end
    end
    assign REQ_VALID = last_valid;
    assign REQ_SRC = last_src;
    assign REQ_LEVEL = last_level;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Request checks look one edge back, since the request toward the
    // CPU is registered one cycle behind the sources and levels.
    // Nothing is checked while reset is high.
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // Reserved bits stay clear, the upper read half is zero, writes land or are refused
    reserved_zero_a: assert property (
        (prio_reg[1][3:0] == 4'h0) && (prio_reg[3][11:7] == 5'h00)
        && (prio_reg[5][15:3] == 13'h0000))
        else $error("reserved bit set");
    top_bits_a: assert property (
        prio_reg[0][15] == 1'b0 && prio_reg[4][7] == 1'b0)
        else $error("reserved bit set");
    rdata_upper_a: assert property (
        RVALID |-> RDATA[31:16] == 16'h0000)
        else $error("upper read half not zero");
    refused_store_a: assert property (
        (do_write && !wr_hit) |=> prio_reg[0] == $past(prio_reg[0]))
        else $error("refused write stored");
    write_lands_a: assert property (
        (do_write && wr_hit && wr_idx == 3'h0 && w_strb == 4'hF)
        |=> prio_reg[0] == ($past(w_data[15:0]) & prio_pkg::MASK_0))
        else $error("write lost");

    // Forwarded request against levels and enables; write response held until taken
    disabled_out_a: assert property (
        REQ_VALID |-> REQ_LEVEL != prio_pkg::LEVEL_OFF)
        else $error("disabled level forwarded");
    level_off_a: assert property (
        (timer1_level == prio_pkg::LEVEL_OFF) |=> !(REQ_VALID && REQ_SRC == 5'h00))
        else $error("disabled source forwarded");
    enable_block_a: assert property (
        (SRC_ENAB == 19'h00000) |=> !REQ_VALID)
        else $error("blocked source forwarded");
    top_level_a: assert property (
        (SRC_PEND[0] && SRC_ENAB[0] && timer1_level == prio_pkg::LEVEL_TOP)
        |=> (REQ_VALID && REQ_LEVEL == 3'h7))
        else $error("level seven not forwarded");
    level_map_a: assert property (
        (SRC_PEND == 19'h00001 && SRC_ENAB[0] && timer1_level != 3'h0)
        |=> (REQ_SRC == 5'h00 && REQ_LEVEL == $past(timer1_level)))
        else $error("level not numeric");
    // Only the two tied sources may be pending, or a third could win
    tie_order_a: assert property (
        (SRC_PEND == 19'h00003 && SRC_ENAB[1:0] == 2'h3 && timer1_level == outcmp1_level
        && timer1_level != 3'h0) |=> REQ_SRC == 5'h00)
        else $error("tie not lowest index");
    req_idle_a: assert property (
        !REQ_VALID |-> (REQ_SRC == 5'h00 && REQ_LEVEL == prio_pkg::LEVEL_OFF))
        else $error("idle request not cleared");
    bresp_hold_a: assert property (
        (BVALID && !BREADY) |=> $stable(BRESP) && BVALID)
        else $error("response dropped");

    // No pending, enabled source may outrank the forwarded one
    for (genvar s = 0; s < prio_pkg::NUM_SRC; s++) begin : g_chk
        win_bound_a: assert property (
            (SRC_PEND[s] && SRC_ENAB[s] && levels[3*s +: 3] != prio_pkg::LEVEL_OFF)
            |=> (REQ_VALID && REQ_LEVEL >= $past(levels[3*s +: 3])))
            else $error("outranked source forwarded");
    end

    // Main scenarios
    cover_write_c: cover property (do_write && wr_hit);
    cover_read_c: cover property (RVALID && RREADY);
    cover_req_c: cover property (REQ_VALID && REQ_LEVEL == 3'h7);
    cover_tie_c: cover property (REQ_VALID && SRC_PEND == 19'h00003 && REQ_SRC == 5'h00);
    cover_refuse_c: cover property (BVALID && BRESP == prio_pkg::RESP_SLVERR);
endmodule : prio_fields
`default_nettype wire

/* dv/src_model.sv */
// Purpose: Interrupt source model holding request and enable lines.
// Assumes: Commanded by the bench on the core clock.
// Notes: Lines are low during reset, like idle peripherals.
`timescale 1ns/1ps
`default_nettype none
module src_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [18:0] pend_cmd,
    input wire logic [18:0] enab_cmd,
    output logic [18:0] pend,
    output logic [18:0] enab
);
    // Pattern latched on load and held until the next one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend <= 19'h0;
            enab <= 19'h0;
        end else if (load) begin
            pend <= pend_cmd;
            enab <= enab_cmd;
        end
    end
endmodule : src_model
`default_nettype wire

/* dv/tb_interrupt_priority_fields.sv */
// Purpose: Self-checking bench for the priority field block.
// Assumes: AXI4-Lite master tasks; source model on the request side.
// Notes: Expectations come from a register and arbitration model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_interrupt_priority_fields;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    logic CORE_CLK = 1'h0;
    logic RST = 1'h1;
    logic [7:0] AWADDR = 8'h0, ARADDR = 8'h0;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'h0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, REQ_VALID;
    logic [1:0] BRESP, RRESP, resp;
    logic [31:0] RDATA, rd, pat;
    logic [4:0] REQ_SRC;
    logic [2:0] REQ_LEVEL;
    logic [18:0] SRC_PEND, SRC_ENAB;
    logic [18:0] pend_cmd = 19'h0, enab_cmd = 19'h0;
    logic load = 1'h0;
    int err_total = 0, check_count = 0;
    // Model registers and writable masks; unlisted bits stay zero
    logic [15:0] mreg [6];
    logic [15:0] mask [6] = '{16'h7777, 16'h7770, 16'h7777, 16'h7077, 16'h7777, 16'h0007};
    // Where each source's field lives
    int src_reg [19] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5};
    int src_lsb [19] = '{12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0, 12, 4, 0, 12, 8, 4, 0, 0};
    // 250 MHz core clock
    always #2 CORE_CLK = ~CORE_CLK;
    prio_fields dut (.CORE_CLK(CORE_CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .SRC_PEND(SRC_PEND), .SRC_ENAB(SRC_ENAB), .REQ_VALID(REQ_VALID), .REQ_SRC(REQ_SRC),
        .REQ_LEVEL(REQ_LEVEL));
    src_model u_src (.clk(CORE_CLK), .rst(RST), .load(load), .pend_cmd(pend_cmd),
        .enab_cmd(enab_cmd), .pend(SRC_PEND), .enab(SRC_ENAB));
    // ------------------------------------------------------------
    // Bus tasks: handshakes sampled at the rising edge, released after it
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        @(posedge CORE_CLK);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        // Each half is released right after the edge that takes it
        do begin
            @(posedge CORE_CLK);
            if (AWVALID && AWREADY) AWVALID <= 1'h0;
            if (WVALID && WREADY) WVALID <= 1'h0;
        end while (BVALID !== 1'h1);
        r = BRESP;
        BREADY <= 1'h0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CORE_CLK);
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        do begin
            @(posedge CORE_CLK);
            if (ARVALID && ARREADY) ARVALID <= 1'h0;
        end while (RVALID !== 1'h1);
        d = RDATA;
        r = RRESP;
        RREADY <= 1'h0;
    endtask : axi_rd
    // Write a register, keep the model in step, read it back
    task automatic wr_chk(input int i, input logic [31:0] d);
        axi_wr(8'(i * 4), d, 4'hF, resp);
        `CHK(resp, 2'h0);
        mreg[i] = d[15:0] & mask[i];
        axi_rd(8'(i * 4), rd, resp);
        `CHK(rd, {16'h0, mreg[i]});
    endtask : wr_chk
    // Present sources, then compare the forwarded request with the model
    task automatic drive_src(input logic [18:0] p, input logic [18:0] e);
        int best, bl, lv;
        @(posedge CORE_CLK);
        pend_cmd <= p;
        enab_cmd <= e;
        load <= 1'h1;
        @(posedge CORE_CLK);
        load <= 1'h0;
        @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        best = -1;
        bl = 0;
        // Strict compare keeps the lowest index on ties and skips level zero
        for (int s = 0; s < 19; s++) begin
            lv = (mreg[src_reg[s]] >> src_lsb[s]) & 7;
            if (p[s] && e[s] && lv > bl) begin
                best = s;
                bl = lv;
            end
        end
        `CHK(REQ_VALID, 1'(best >= 0));
        if (best >= 0) begin
            `CHK(REQ_SRC, 5'(best));
            `CHK(REQ_LEVEL, 3'(bl));
        end
        // Status word mirrors the forwarded request while the sources stand
        axi_rd(8'h18, rd, resp);
        `CHK(rd, {23'h0, 1'(best >= 0), ((best >= 0) ? 5'(best) : 5'h00), 3'(bl)});
    endtask : drive_src
    task automatic tally_and_finish;
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h3509fdcf));
        repeat (20) @(posedge CORE_CLK);
        RST <= 1'h0;
        // Reset values, every field at level four
        for (int i = 0; i < 6; i++) begin
            mreg[i] = 16'h4444 & mask[i];
            axi_rd(8'(i * 4), rd, resp);
            `CHK(rd, {16'h0, mreg[i]});
        end
        drive_src(19'h7FFFF, 19'h7FFFF);
        // All ones: top level everywhere, tie to lowest index, enables block
        for (int i = 0; i < 6; i++) wr_chk(i, 32'hFFFFFFFF);
        drive_src(19'h7FFFF, 19'h7FFFF);
        drive_src(19'h7FFFF, 19'h0);
        drive_src(19'h00003, 19'h00003);
        drive_src(19'h00001, 19'h7FFFF);
        // All zeros: every source disabled
        for (int i = 0; i < 6; i++) wr_chk(i, 32'h0);
        drive_src(19'h7FFFF, 19'h7FFFF);
        // An unmapped read, a status write and an unaligned write are refused
        axi_rd(8'h1C, rd, resp);
        `CHK(resp, 2'h2);
        `CHK(rd, 32'h0);
        axi_wr(8'h18, 32'hFFFF, 4'hF, resp);
        `CHK(resp, 2'h2);
        axi_wr(8'h02, 32'hFFFF, 4'hF, resp);
        `CHK(resp, 2'h2);
        axi_rd(8'h00, rd, resp);
        `CHK(rd, 32'h0);
        // Random levels and source patterns
        repeat (40) begin
            for (int i = 0; i < 6; i++) wr_chk(i, $urandom);
            pat = $urandom;
            drive_src(19'($urandom), pat[18:0] | 19'($urandom));
        end
        // Upper byte lane only: the low byte keeps its fields
        axi_wr(8'h00, 32'h00007777, 4'h2, resp);
        `CHK(resp, 2'h0);
        mreg[0] = (16'h7700 | (mreg[0] & 16'h00FF)) & mask[0];
        axi_rd(8'h00, rd, resp);
        `CHK(rd, {16'h0, mreg[0]});
        tally_and_finish();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb_interrupt_priority_fields
`default_nettype wire
